// ==== hw/swl_consts.svh ====
// Constants for the supply warning limit and status bank: command codes,
// field positions, reset values and register widths.
// Assumes a PMBus protocol engine outside decodes frames into commands.
//
// Notes on behaviour
// R1: Undervoltage limit is 12 bits, upper four zero
// R2: Undervoltage limit resets zero, which disables warning
// R3: Overpower limit is 16 bits, resets 0x7fff
// R4: Overpower compares by sign of the limit
// R5: Status byte is status word low byte
// R6: Communication errors latch status byte bit 1
// R7: Status byte bit 0 shows other active status
// R8: Status word bit 14 mirrors current status
// R9: Status word bit 13 mirrors input status
// R10: Status word bit 12 mirrors maker status
// R11: Status word bits 15, 11:8 read zero
// R12: Clear-faults command clears every latched bit
// R13: Overpower sets input status bit 0, latched
// R14: Undervoltage sets input status bit 5, latched
// R15: Compare once per conversion; reserved writes ignored
`ifndef SWL_CONSTS_SVH
`define SWL_CONSTS_SVH

// ==========================================================================
// Command codes
`define SWL_CMD_CLEAR_FAULTS   8'h03
`define SWL_CMD_VIN_LOW_LIM    8'h58
`define SWL_CMD_PIN_HIGH_LIM   8'h6b
`define SWL_CMD_STATUS_LOW     8'h78
`define SWL_CMD_STATUS_FULL    8'h79

// ==========================================================================
// Reset values and field widths
`define SWL_VIN_LIM_RESET      12'h000
`define SWL_PIN_LIM_RESET      16'h7fff
`define SWL_VIN_LIM_W          12

// ==========================================================================
// Bit positions
`define SWL_SB_CML_BIT         1
`define SWL_SB_OTHER_BIT       0
`define SWL_SW_IOUT_BIT        14
`define SWL_SW_INPUT_BIT       13
`define SWL_SW_MFR_BIT         12
`define SWL_IN_VOV_BIT         6
`define SWL_IN_VUV_BIT         5
`define SWL_IN_POP_BIT         0

`endif

// ==== hw/swl_pkg.sv ====
// Types shared by the supply warning limit and status bank.
// Assumes nothing beyond a SystemVerilog compiler.
package swl_pkg;
  // ========================================================================
  // Word types
  typedef logic [7:0]  swl_code_t;
  typedef logic [15:0] swl_word_t;
  typedef logic [7:0]  swl_byte_t;
endpackage

// ==== hw/swl_limit_cmp.sv ====
// Threshold comparator: checks a finished conversion against both limits.
// Assumes readings are stable in the cycle that convDone is high.
`timescale 1ns/1ps
`include "swl_consts.svh"

module swl_limit_cmp #(
  parameter int VIN_W = `SWL_VIN_LIM_W
) (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 convDone,
  input  wire logic [VIN_W-1:0]     vinReading,
  input  wire logic [15:0]          pinReading,
  input  wire logic [VIN_W-1:0]     vinLowLimit,
  input  wire logic [15:0]          pinHighLimit,
  output logic                      uvEvent_q,
  output logic                      opEvent_q
);
  import swl_pkg::*;

  logic signed [15:0] pinS;
  logic signed [15:0] limS;
  logic               opHit;

  // ========================================================================
  // Overpower direction follows the sign of the limit; zero counts positive
  assign pinS  = signed'(pinReading);
  assign limS  = signed'(pinHighLimit);
  assign opHit = limS[15] ? (pinS < limS) : (pinS > limS); // R4

  // Events are one-cycle pulses, only on a finished conversion; a zero limit
  // can never be undercut, which is what disables the warning
  always_ff @(posedge core_clk) begin
    if (reset) begin
      uvEvent_q <= 1'b0;
      opEvent_q <= 1'b0;
    end else begin
      uvEvent_q <= convDone && (vinReading < vinLowLimit); // R15 R2
      opEvent_q <= convDone && opHit; // R15
    end
  end
endmodule // swl_limit_cmp

// ==== hw/swl_status_bank.sv ====
// Register bank holding the input undervoltage and overpower limits, the
// input status bits they set, and the summary status byte and word.
// Assumes a protocol engine decodes PMBus frames into one-cycle commands,
// reports frame errors as pulses, and that other status registers report
// whether they hold active bits.
// Writes to the read-only codes are dropped silently; the engine is
// expected to flag them as unsupported if that is wanted.
`timescale 1ns/1ps
`include "swl_consts.svh"

module swl_status_bank #(
  parameter int VIN_W = `SWL_VIN_LIM_W
) (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // Command port from the protocol engine
  input  wire logic                 cmdValid,
  input  wire logic                 cmdWrite,
  input  wire swl_pkg::swl_code_t   cmdCode,
  input  wire swl_pkg::swl_word_t   cmdData,
  input  wire logic                 commError,
  output swl_pkg::swl_word_t        rdData_q,
  output logic                      rdValid_q,
  output logic                      rdHit_q,
  // Measurement side
  input  wire logic                 convDone,
  input  wire logic [VIN_W-1:0]     vinReading,
  input  wire logic [15:0]          pinReading,
  input  wire logic                 vinOvEvent,
  // Summary of status groups held elsewhere
  input  wire logic                 ioutActive,
  input  wire logic                 mfrActive,
  output logic                      clearFaults_q,
  output swl_pkg::swl_byte_t        inputStatus_q,
  output swl_pkg::swl_word_t        statusWord_q
);
  import swl_pkg::*;

  logic [VIN_W-1:0] vinLowLimit_q;
  swl_word_t        pinHighLimit_q;
  logic             cmlFault_q;
  logic             vinUv_q;
  logic             vinOv_q;
  logic             pinOp_q;
  logic             uvEvent;
  logic             opEvent;
  logic             clearCmd;
  logic             writeVinLim;
  logic             writePinLim;
  logic             readCmd;
  logic             inputActive;
  swl_word_t        statusWord_d;

  // ========================================================================
  // Command decode; every strobe line is an argument so that a continuous
  // assignment calling these functions is re-evaluated when they change
  function automatic logic isWrite(
    input logic      valid,
    input logic      write,
    input swl_code_t got,
    input swl_code_t want
  );
    isWrite = valid && write && (got == want);
  endfunction

  function automatic logic isRead(
    input logic valid,
    input logic write
  );
    isRead = valid && !write;
  endfunction

  assign clearCmd    = isWrite(cmdValid, cmdWrite, cmdCode, `SWL_CMD_CLEAR_FAULTS); // R12
  assign writeVinLim = isWrite(cmdValid, cmdWrite, cmdCode, `SWL_CMD_VIN_LOW_LIM);
  assign writePinLim = isWrite(cmdValid, cmdWrite, cmdCode, `SWL_CMD_PIN_HIGH_LIM);
  assign readCmd     = isRead(cmdValid, cmdWrite);

  // ========================================================================
  // Limit registers; reserved bits of the low limit are never stored
  // A new limit applies from the next finished conversion onwards
  always_ff @(posedge core_clk) begin
    if (reset) begin
      vinLowLimit_q  <= `SWL_VIN_LIM_RESET; // R2
      pinHighLimit_q <= `SWL_PIN_LIM_RESET; // R3
    end else begin
      if (writeVinLim) begin
        vinLowLimit_q <= cmdData[VIN_W-1:0]; // R1 R15
      end
      if (writePinLim) begin
        pinHighLimit_q <= cmdData; // R3
      end
    end
  end

  // ========================================================================
  // Threshold checks, once per finished conversion
  swl_limit_cmp #(
    .VIN_W        (VIN_W)
  ) u_cmp (
    .core_clk     (core_clk),
    .reset        (reset),
    .convDone     (convDone),
    .vinReading   (vinReading),
    .pinReading   (pinReading),
    .vinLowLimit  (vinLowLimit_q),
    .pinHighLimit (pinHighLimit_q),
    .uvEvent_q    (uvEvent),
    .opEvent_q    (opEvent)
  );

  // ========================================================================
  // Latched flags; an event in the clearing cycle wins so it is not lost
  always_ff @(posedge core_clk) begin
    if (reset) begin
      vinUv_q <= 1'b0;
    end else begin
      vinUv_q <= uvEvent | (vinUv_q & ~clearCmd); // R14 R12
    end
  end

  // Overvoltage comes from a comparator outside this bank, latched here
  always_ff @(posedge core_clk) begin
    if (reset) begin
      vinOv_q <= 1'b0;
    end else begin
      vinOv_q <= vinOvEvent | (vinOv_q & ~clearCmd); // R12
    end
  end

  // Overpower latch, set by the comparator pulse
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pinOp_q <= 1'b0;
    end else begin
      pinOp_q <= opEvent | (pinOp_q & ~clearCmd); // R13 R12
    end
  end

  // Communication fault from the engine latches until clear-faults
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmlFault_q <= 1'b0;
    end else begin
      cmlFault_q <= commError | (cmlFault_q & ~clearCmd); // R6 R12
    end
  end

  // Clear pulse forwarded so the status registers held elsewhere clear too
  always_ff @(posedge core_clk) begin
    if (reset) begin
      clearFaults_q <= 1'b0;
    end else begin
      clearFaults_q <= clearCmd; // R12
    end
  end

  // ========================================================================
  // Summary word; live bits are rebuilt every cycle, one cycle behind
  assign inputActive = vinUv_q | vinOv_q | pinOp_q;

  always_comb begin
    statusWord_d                     = 16'h0000; // R11
    statusWord_d[`SWL_SW_IOUT_BIT]   = ioutActive; // R8
    statusWord_d[`SWL_SW_INPUT_BIT]  = inputActive; // R9
    statusWord_d[`SWL_SW_MFR_BIT]    = mfrActive; // R10
    statusWord_d[`SWL_SB_CML_BIT]    = cmlFault_q; // R6
    statusWord_d[`SWL_SB_OTHER_BIT]  = ioutActive | inputActive | mfrActive; // R7
  end

  // Status word register, rebuilt every cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      statusWord_q <= 16'h0000;
    end else begin
      statusWord_q <= statusWord_d;
    end
  end

  // Input status byte; reserved bits 7 and 4:1 stay zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      inputStatus_q <= 8'h00;
    end else begin
      inputStatus_q <= {1'b0, vinOv_q, vinUv_q, 4'h0, pinOp_q}; // R13 R14
    end
  end

  // ========================================================================
  // Read path: answer one cycle after the command, zero-extended
  // Unknown codes still answer, with no hit, so the engine can flag them
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdValid_q <= 1'b0;
      rdHit_q   <= 1'b0;
      rdData_q  <= 16'h0000;
    end else begin
      rdValid_q <= readCmd;
      rdHit_q   <= 1'b0;
      rdData_q  <= 16'h0000;
      if (readCmd) begin
        case (cmdCode)
          `SWL_CMD_VIN_LOW_LIM: begin
            rdHit_q  <= 1'b1;
            rdData_q <= {4'h0, vinLowLimit_q}; // R1
          end
          `SWL_CMD_PIN_HIGH_LIM: begin
            rdHit_q  <= 1'b1;
            rdData_q <= pinHighLimit_q;
          end
          `SWL_CMD_STATUS_LOW: begin
            rdHit_q  <= 1'b1;
            rdData_q <= {8'h00, statusWord_q[7:0]}; // R5
          end
          `SWL_CMD_STATUS_FULL: begin
            rdHit_q  <= 1'b1;
            rdData_q <= statusWord_q; // R5
          end
          default: begin
            rdHit_q  <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // swl_status_bank

// ==== tb/swl_status_bank_properties.sv ====
// Checker for the supply warning bank: read answers, live and latched bits.
// Sees only the bank's ports; bound to every swl_status_bank instance.
`timescale 1ns/1ps
module swl_status_bank_properties (
  input wire logic               core_clk,
  input wire logic               reset,
  input wire logic               cmdValid,
  input wire logic               cmdWrite,
  input wire swl_pkg::swl_code_t cmdCode,
  input wire logic               commError,
  input wire swl_pkg::swl_word_t rdData_q,
  input wire logic               rdValid_q,
  input wire logic               rdHit_q,
  input wire logic               convDone,
  input wire logic               ioutActive,
  input wire logic               mfrActive,
  input wire logic               clearFaults_q,
  input wire swl_pkg::swl_byte_t inputStatus_q,
  input wire swl_pkg::swl_word_t statusWord_q
);
  import swl_pkg::*;
  // ==========================================================================
  // Properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_RSVD_ZERO: assert property (statusWord_q[15] == 1'h0 && statusWord_q[11:8] == 4'h0)
    else $error("status word reserved bit set");
  AST_CML_LATCH: assert property (commError ##1 !cmdValid |-> ##1 statusWord_q[1])
    else $error("comm fault not latched");
  // Skip the edge after reset, where the past input was masked by reset
  AST_LIVE_MIRROR: assert property (!$past(reset) |-> statusWord_q[14] == $past(ioutActive)
    && statusWord_q[12] == $past(mfrActive)) else $error("live group bits wrong");
  AST_INPUT_SUM: assert property (statusWord_q[13] == (|inputStatus_q))
    else $error("input summary wrong");
  AST_OTHER_SUM: assert property (statusWord_q[0] == (|statusWord_q[14:12]))
    else $error("other status bit wrong");
  AST_BYTE_READ: assert property (cmdValid && !cmdWrite && cmdCode == 8'h78 ##1
    $stable(statusWord_q) |-> rdValid_q && rdHit_q && rdData_q == {8'h00, statusWord_q[7:0]})
    else $error("status byte read wrong");
  AST_VIN_HIGH: assert property (cmdValid && !cmdWrite && cmdCode == 8'h58 |=>
    rdHit_q && rdData_q[15:12] == 4'h0) else $error("limit high bits set");
  AST_CLEAR: assert property (cmdValid && cmdWrite && cmdCode == 8'h03 |=> clearFaults_q)
    else $error("clear pulse missing");
  AST_UV_CAUSE: assert property ($rose(inputStatus_q[5]) |-> $past(convDone, 3))
    else $error("undervoltage without conversion");
endmodule // swl_status_bank_properties

bind swl_status_bank swl_status_bank_properties chk (.*);

// ==== tb/swl_host_model.sv ====
// Host-side command source: turns bench requests into one-cycle commands.
// Assumes the bench changes go, wr, code and data at rising edges.
`timescale 1ns/1ps
module swl_host_model (
  input  wire logic               core_clk,
  input  wire logic               go,
  input  wire logic               wr,
  input  wire swl_pkg::swl_code_t code,
  input  wire swl_pkg::swl_word_t data,
  output swl_pkg::swl_code_t      cmdCode,
  output swl_pkg::swl_word_t      cmdData,
  output logic                    cmdValid,
  output logic                    cmdWrite
);
  import swl_pkg::*;
  initial {cmdValid, cmdWrite, cmdCode, cmdData} = '0;
  // One strobe per request; idle lines toggle so stale values never look valid
  always @(posedge core_clk) begin
    cmdValid <= go;
    cmdWrite <= go ? wr : ~cmdWrite;
    cmdCode  <= go ? code : ~cmdCode;
    cmdData  <= (go && code != 8'h03) ? data : ~cmdData;
  end
endmodule // swl_host_model

// ==== tb/supply_warning_limits_and_status_bench.sv ====
// Self-checking bench for the supply warning limit and status bank.
// Assumes the bank, the host model and the checker bind are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checkCount++; if ((a) !== (e)) begin nErrors++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end
module supply_warning_limits_and_status_bench;
  import swl_pkg::*;
  typedef struct {logic wr; swl_code_t code; swl_word_t data; logic hit;
    swl_word_t exp;} swl_row_t;
  logic      core_clk = 0, reset = 1, go = 0, wr = 0, convDone = 0, commError = 0;
  logic      vinOvEvent = 0, ioutActive = 0, mfrActive = 0, cmdValid, cmdWrite;
  logic      rdValid_q, rdHit_q, clearFaults_q;
  logic [11:0] vinReading = 12'h000;
  swl_code_t code = 8'h00, cmdCode;
  swl_byte_t inputStatus_q;
  swl_word_t data = 16'h0000, pinReading = 16'h0000, cmdData, rdData_q, statusWord_q;
  int        nErrors = 0, checkCount = 0;
  // Reset values, masked and ignored writes, unknown code
  swl_row_t  rows [7] = '{'{1'h0, 8'h58, 16'h0000, 1'h1, 16'h0000},
    '{1'h0, 8'h6b, 16'h0000, 1'h1, 16'h7fff}, '{1'h1, 8'h58, 16'hffff, 1'h1, 16'h0fff},
    '{1'h1, 8'h6b, 16'h8001, 1'h1, 16'h8001}, '{1'h1, 8'h79, 16'hffff, 1'h1, 16'h0000},
    '{1'h1, 8'h78, 16'h00ff, 1'h1, 16'h0000}, '{1'h0, 8'hab, 16'h0000, 1'h0, 16'h0000}};
  always #5 core_clk = ~core_clk;
  swl_host_model host (.core_clk(core_clk), .go(go), .wr(wr), .code(code), .data(data),
    .cmdCode(cmdCode), .cmdData(cmdData), .cmdValid(cmdValid), .cmdWrite(cmdWrite));
  swl_status_bank dut (.core_clk(core_clk), .reset(reset), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData), .commError(commError),
    .rdData_q(rdData_q), .rdValid_q(rdValid_q), .rdHit_q(rdHit_q), .convDone(convDone),
    .vinReading(vinReading), .pinReading(pinReading), .vinOvEvent(vinOvEvent),
    .ioutActive(ioutActive), .mfrActive(mfrActive), .clearFaults_q(clearFaults_q),
    .inputStatus_q(inputStatus_q), .statusWord_q(statusWord_q));
  // ==========================================================================
  // Tasks: command ends one cycle after it is taken, so a read answer stands
  task automatic cmd(input logic w, input swl_code_t c, input swl_word_t d);
    @(posedge core_clk);
    {go, wr, code, data} <= {1'h1, w, c, d};
    @(posedge core_clk);
    go <= 1'h0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic conv(input logic [11:0] v, input swl_word_t p);
    @(posedge core_clk);
    {convDone, vinReading, pinReading} <= {1'h1, v, p};
    @(posedge core_clk);
    convDone <= 1'h0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic chk(input swl_byte_t i, input swl_word_t w);
    #1;
    `CHK("inputStatus", i, inputStatus_q)
    `CHK("statusWord", w, statusWord_q)
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'h0;
    foreach (rows[i]) begin
      if (rows[i].wr) cmd(1'h1, rows[i].code, rows[i].data);
      cmd(1'h0, rows[i].code, 16'h0000);
      `CHK("readHit", {1'h1, rows[i].hit}, {rdValid_q, rdHit_q})
      `CHK("read", rows[i].exp, rdData_q)
    end
    $display("register table done");
    conv(12'hfff, 16'h8002);
    chk(8'h00, 16'h0000);
    conv(12'hffe, 16'h8000);
    chk(8'h21, 16'h2001);
    cmd(1'h1, 8'h03, 16'h0000);
    repeat (2) @(posedge core_clk);
    chk(8'h00, 16'h0000);
    cmd(1'h1, 8'h6b, 16'h0010);
    conv(12'hfff, 16'h0010);
    chk(8'h00, 16'h0000);
    conv(12'hfff, 16'h0011);
    chk(8'h01, 16'h2001);
    $display("threshold test done");
    // Fault, external event and live groups all at once
    @(posedge core_clk);
    {commError, vinOvEvent, ioutActive, mfrActive} <= 4'hf;
    @(posedge core_clk);
    {commError, vinOvEvent} <= 2'h0;
    repeat (3) @(posedge core_clk);
    chk(8'h41, 16'h7003);
    cmd(1'h0, 8'h79, 16'h0000);
    `CHK("wordRead", 17'h17003, {rdHit_q, rdData_q})
    cmd(1'h0, 8'h78, 16'h0000);
    `CHK("byteRead", 17'h10003, {rdHit_q, rdData_q})
    cmd(1'h1, 8'h03, 16'h0000);
    repeat (2) @(posedge core_clk);
    chk(8'h00, 16'h5001);
    $display("status test done");
    // Second reset: defaults must leave both warnings disabled
    @(posedge core_clk);
    {reset, ioutActive, mfrActive} <= 3'h4;
    repeat (2) @(posedge core_clk);
    reset <= 1'h0;
    conv(12'h000, 16'h7fff);
    chk(8'h00, 16'h0000);
    $display("reset test done");
    summarize();
  end
  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #100000;
    nErrors++;
    summarize();
  end
endmodule // supply_warning_limits_and_status_bench
